// [hw/hdg_gen.sv]
/*
  multi-tt high-speed hub descriptor generator: builds the standard device
  and configuration descriptors from fixed values and loaded configuration,
  and answers byte reads by offset.
  assumes cfg is stable from the same clock domain; any change of cfg
  rebuilds the image, during which ready is low.
*/
// Contract
// - device descriptor starts with length 12h then type 01h
// - bytes two and three hold release 0200h, low byte first
// - class byte 09h at offset 4, subclass 00h at offset 5
// - protocol byte at offset 6 is 02h for multi-tt
// - vendor, product, device ids two bytes each at 8, 10, 12 from config
// - string indexes 00 when strings off, else 01, 02, 03
// - config descriptor length 09h, type 02h, total length 0029h
// - config descriptor reports one interface, value 01h at offset 4
// - configuration value at offset 5 is 01h
// - configuration string index at offset 6 is 00h
// - attributes always advertise remote wakeup
// - attributes A0h when bus powered, E0h when self powered
// - max power byte counts total bus draw in 2 mA units
// - max power chooses bus or self powered value by power select
// - both current values come from loaded configuration, never constants
`timescale 1ns/1ps
module hdg_gen
  import hdg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire hdg_cfg_s cfg,
  input wire logic rd_req,
  input wire hdg_req_s rd_sel,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic ready
);

  hdg_state_e state;
  hdg_cfg_s cfg_q;
  logic [ROM_AW-1:0] build_idx;
  logic [7:0] build_byte;
  logic [ROM_AW-1:0] rd_addr;
  logic rd_pend;
  logic rom_wr;
  logic [7:0] rom_q;

  function automatic logic [7:0] lo_b(input logic [15:0] v);
    return v[7:0];
  endfunction : lo_b

  function automatic logic [7:0] hi_b(input logic [15:0] v);
    return v[15:8];
  endfunction : hi_b

  // image byte at a flat index; configuration bytes follow the device ones
  always_comb begin
    build_byte = RST_BYTE;
    unique case (build_idx)
      5'h00: build_byte = DEV_LEN;
      5'h01: build_byte = DEV_TYPE;
      5'h02: build_byte = lo_b(SPEC_REL);
      5'h03: build_byte = hi_b(SPEC_REL);
      5'h04: build_byte = HUB_CLASS;
      5'h05: build_byte = HUB_SUBCLASS;
      5'h06: build_byte = PROTO_MULTI_TT;
      5'h07: build_byte = EP0_MAX_PKT;
      OFS_VID: build_byte = lo_b(cfg_q.vendor_id);
      5'h09: build_byte = hi_b(cfg_q.vendor_id);
      OFS_PID: build_byte = lo_b(cfg_q.product_id);
      5'h0b: build_byte = hi_b(cfg_q.product_id);
      OFS_DID: build_byte = lo_b(cfg_q.device_id);
      5'h0d: build_byte = hi_b(cfg_q.device_id);
      OFS_STR: build_byte = cfg_q.string_en ? STR_MFR : STR_NONE;
      5'h0f: build_byte = cfg_q.string_en ? STR_PROD : STR_NONE;
      5'h10: build_byte = cfg_q.string_en ? STR_SER : STR_NONE;
      5'h11: build_byte = NUM_CONFIGS;
      CFG_BASE: build_byte = CFG_LEN;
      5'h13: build_byte = CFG_TYPE;
      5'h14: build_byte = lo_b(CFG_TOTAL_LEN);
      5'h15: build_byte = hi_b(CFG_TOTAL_LEN);
      5'h16: build_byte = CFG_NUM_IF;
      5'h17: build_byte = CFG_VALUE;
      5'h18: build_byte = CFG_STR_IDX;
      // remote wakeup bit set in both codes
      5'h19: build_byte = cfg_q.self_power_select ? ATTR_SELF_PWR : ATTR_BUS_PWR;
      // value in 2 ma units, chosen from loaded data
      ROM_LAST: build_byte = cfg_q.self_power_select ? cfg_q.self_powered_max_current
                                                       : cfg_q.bus_powered_max_current;
      default: build_byte = RST_BYTE;
    endcase
  end

  // build sequencer: rebuild whenever the loaded configuration changes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= HDG_IDLE;
      build_idx <= '0;
    end else if (ce) begin
      unique case (state)
        HDG_IDLE: begin
          state <= HDG_BUILD;
          build_idx <= '0;
        end
        HDG_BUILD: begin
          if (build_idx == ROM_LAST) begin
            state <= HDG_READY;
          end else begin
            build_idx <= 5'(build_idx + 5'h01);
          end
        end
        HDG_READY: begin
          if (cfg != cfg_q) begin
            state <= HDG_IDLE;
          end
        end
        default: state <= HDG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= '0;
    end else if (ce && state == HDG_IDLE) begin
      cfg_q <= cfg;
    end
  end

  assign rom_wr = (state == HDG_BUILD);
  assign rd_addr = rd_sel.cfg_desc ? 5'(rd_sel.offset + CFG_BASE) : rd_sel.offset;

  hdg_rom u_rom (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .wr_en(rom_wr),
    .wr_addr(build_idx),
    .wr_data(build_byte),
    .rd_addr(rd_addr),
    .rd_data(rom_q)
  );

  // requests taken only while the ready output stands; offsets beyond a descriptor are refused, rd_valid stays low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_pend <= 1'b0;
    end else if (ce) begin
      rd_pend <= rd_req && ready && state == HDG_READY &&
                 (rd_sel.cfg_desc ? rd_sel.offset < 5'(CFG_BYTES)
                                  : rd_sel.offset < 5'(DEV_BYTES));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_data <= RST_BYTE;
      ready <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_pend;
      rd_data <= rd_pend ? rom_q : RST_BYTE;
      ready <= (state == HDG_READY) && (cfg == cfg_q);
    end
  end

endmodule : hdg_gen

// [hw/hdg_pkg.sv]
/*
  package for the multi-tt hub descriptor generator: descriptor field values,
  byte offsets, reset values and the carrier structs.
  assumes nothing beyond a systemverilog compiler.
*/
package hdg_pkg;

  localparam logic [7:0] DEV_LEN = 8'h12;
  localparam logic [7:0] DEV_TYPE = 8'h01;
  localparam logic [15:0] SPEC_REL = 16'h0200;
  localparam logic [7:0] HUB_CLASS = 8'h09;
  localparam logic [7:0] HUB_SUBCLASS = 8'h00;
  localparam logic [7:0] PROTO_MULTI_TT = 8'h02;
  localparam logic [7:0] EP0_MAX_PKT = 8'h40;
  localparam logic [7:0] NUM_CONFIGS = 8'h01;
  localparam logic [7:0] STR_NONE = 8'h00;
  localparam logic [7:0] STR_MFR = 8'h01;
  localparam logic [7:0] STR_PROD = 8'h02;
  localparam logic [7:0] STR_SER = 8'h03;

  localparam logic [7:0] CFG_LEN = 8'h09;
  localparam logic [7:0] CFG_TYPE = 8'h02;
  localparam logic [15:0] CFG_TOTAL_LEN = 16'h0029;
  localparam logic [7:0] CFG_NUM_IF = 8'h01;
  localparam logic [7:0] CFG_VALUE = 8'h01;
  localparam logic [7:0] CFG_STR_IDX = 8'h00;
  localparam logic [7:0] ATTR_BUS_PWR = 8'ha0;
  localparam logic [7:0] ATTR_SELF_PWR = 8'he0;

  // descriptor sizes and offset space
  localparam int DEV_BYTES = 18;
  localparam int CFG_BYTES = 9;
  localparam int ROM_AW = 5;
  localparam logic [ROM_AW-1:0] CFG_BASE = 5'h12;
  localparam logic [ROM_AW-1:0] ROM_LAST = 5'h1a;

  // device descriptor offsets
  localparam logic [4:0] OFS_VID = 5'h08;
  localparam logic [4:0] OFS_PID = 5'h0a;
  localparam logic [4:0] OFS_DID = 5'h0c;
  localparam logic [4:0] OFS_STR = 5'h0e;

  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic [15:0] device_id;
    logic string_en;
    logic self_power_select;
    logic [7:0] bus_powered_max_current;
    logic [7:0] self_powered_max_current;
  } hdg_cfg_s;

  typedef struct packed {
    logic cfg_desc;
    logic [4:0] offset;
  } hdg_req_s;

  typedef enum logic [1:0] {
    HDG_IDLE = 2'b00,
    HDG_BUILD = 2'b01,
    HDG_READY = 2'b11
  } hdg_state_e;

endpackage : hdg_pkg

// [hw/hdg_rom.sv]
/*
  small byte memory holding the assembled descriptors, device descriptor
  first then configuration descriptor; read data is registered.
  assumes a single clock and a writer that fills it before reads matter.
*/
`timescale 1ns/1ps
module hdg_rom
  import hdg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [ROM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [ROM_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [0:DEV_BYTES+CFG_BYTES-1];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= RST_BYTE;
    end else if (ce) begin
      rd_data <= (rd_addr <= ROM_LAST) ? mem[rd_addr] : RST_BYTE;
    end
  end

endmodule : hdg_rom

// [test/hdg_gen_monitor.sv]
/* port checker for hdg_gen.
   bound to hdg_gen; one clock. */
`timescale 1ns/1ps
module hdg_mon
  import hdg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire hdg_cfg_s cfg,
  input wire logic rd_req,
  input wire hdg_req_s rd_sel,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire ok = rd_sel.cfg_desc ? rd_sel.offset < 9 : rd_sel.offset < 18;
  wire sp = cfg.self_power_select;
  take_lat_a: assert property (rd_req && ce && ready && ok && $stable(cfg) ##1 ce[*2] |-> rd_valid)
    else $error("answer missing");
  refuse_a: assert property (rd_req && ce && !(ready && ok) ##1 ce |-> ##1 !rd_valid)
    else $error("refused request answered");
  idle_zero_a: assert property (!rd_valid |-> rd_data == 8'h00)
    else $error("data without valid");
  cfg_drop_a: assert property (ready && ce && !$stable(cfg) |=> !ready)
    else $error("ready kept after cfg change");
  dev_len_a: assert property (rd_valid && $past(rd_sel, 2) == 6'h00 |-> rd_data == 8'h12)
    else $error("bad length byte");
  proto_a: assert property (rd_valid && $past(rd_sel, 2) == 6'h06 |-> rd_data == 8'h02)
    else $error("bad protocol byte");
  str_idx_a: assert property (rd_valid && $past(rd_sel, 2) == 6'h0e |-> rd_data == {7'h0, cfg.string_en})
    else $error("bad string index");
  attr_a: assert property (rd_valid && $past(rd_sel, 2) == 6'h27 |-> rd_data == (sp ? 8'he0 : 8'ha0))
    else $error("bad attributes");
  pwr_a: assert property (rd_valid && $past(rd_sel, 2) == 6'h28 |->
    rd_data == (sp ? cfg.self_powered_max_current : cfg.bus_powered_max_current))
    else $error("bad max power");
endmodule : hdg_mon
bind hdg_gen hdg_mon mon_u (.clk, .rstn, .ce, .cfg, .rd_req, .rd_sel, .rd_data, .rd_valid, .ready);

// [test/hdg_host.sv]
/* host model reading descriptor bytes one at a time.
   drives at the falling edge of clk. */
`timescale 1ns/1ps
module hdg_host
  import hdg_pkg::*;
(
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output hdg_req_s rd_sel
);
  initial begin
    rd_req = 1'b0;
    rd_sel = '0;
  end
  task rd(input hdg_req_s s, output logic [7:0] d, output bit got);
    @(negedge clk);
    rd_req = 1'b1;
    rd_sel = s;
    @(negedge clk);
    rd_req = 1'b0;
    // released select shows a changed pattern
    rd_sel = ~s;
    got = 0;
    d = 8'h00;
    repeat (6) begin
      @(negedge clk);
      if (rd_valid === 1'b1 && !got) begin
        got = 1;
        d = rd_data;
      end
    end
  endtask : rd
endmodule : hdg_host

// [test/hdg_gen_tb.sv]
/* self-checking bench for hdg_gen.
   uses hdg_host as the reading side. */
`timescale 1ns/1ps
module hdg_gen_tb
  import hdg_pkg::*;
;
  logic clk = 0, rstn = 0, ce = 1, rd_req, rd_valid, ready;
  logic [7:0] rd_data;
  hdg_req_s rd_sel;
  hdg_cfg_s cfg = {16'h1a2b, 16'h3c4d, 16'h5e6f, 1'b1, 1'b0, 8'h32, 8'h05};
  int err_total = 0, n_tests = 0;
  always #5 clk = ~clk;
  hdg_gen dut_u (.clk, .rstn, .ce, .cfg, .rd_req, .rd_sel, .rd_data, .rd_valid, .ready);
  hdg_host host_u (.clk, .rd_valid, .rd_data, .rd_req, .rd_sel);
  task end_of_test;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task bad(input string m);
    err_total++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) bad($sformatf("byte %h want %h", g, e));
  endtask : chk
  task chk_f(input logic g, input logic e);
    n_tests++;
    if (g !== e) bad("valid flag");
  endtask : chk_f
  function automatic logic [7:0] exp_b(input logic c, input logic [4:0] o);
    logic [7:0] d [27];
    d = '{8'h12, 8'h01, 8'h00, 8'h02, 8'h09, 8'h00, 8'h02, 8'h40,
      cfg.vendor_id[7:0], cfg.vendor_id[15:8], cfg.product_id[7:0], cfg.product_id[15:8],
      cfg.device_id[7:0], cfg.device_id[15:8], {7'h0, cfg.string_en},
      {6'h0, cfg.string_en, 1'b0}, {6'h0, {2{cfg.string_en}}}, 8'h01,
      8'h09, 8'h02, 8'h29, 8'h00, 8'h01, 8'h01, 8'h00,
      cfg.self_power_select ? 8'he0 : 8'ha0,
      cfg.self_power_select ? cfg.self_powered_max_current : cfg.bus_powered_max_current};
    return d[c ? o + 18 : o];
  endfunction : exp_b
  task rd1(input logic c, input logic [4:0] o, input bit v);
    logic [7:0] d;
    bit got;
    host_u.rd({c, o}, d, got);
    chk_f(got, v);
    chk(d, v ? exp_b(c, o) : 8'h00);
  endtask : rd1
  task wait_ready;
    int k;
    k = 0;
    repeat (2) @(negedge clk);
    while (ready !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    if (ready !== 1'b1) begin
      bad("ready timeout");
      end_of_test;
    end
  endtask : wait_ready
  task t_dev;
    for (int s = 1; s >= 0; s--) begin
      cfg.string_en = s[0];
      wait_ready;
      for (int i = 0; i < 18; i++) rd1(0, 5'(i), 1);
    end
    $display("device descriptor done");
  endtask : t_dev
  task t_cfg;
    for (int p = 0; p < 2; p++) begin
      cfg.self_power_select = p[0];
      wait_ready;
      for (int i = 0; i < 9; i++) rd1(1, 5'(i), 1);
    end
    $display("configuration descriptor done");
  endtask : t_cfg
  task t_ref;
    rd1(0, 5'd18, 0);
    rd1(1, 5'd9, 0);
    cfg.vendor_id = 16'h9a87;
    cfg.self_powered_max_current = 8'h7e;
    rd1(0, 5'd8, 0);
    wait_ready;
    rd1(0, 5'd8, 1);
    rd1(1, 5'd8, 1);
    $display("refusal and reload done");
  endtask : t_ref
  task t_ce;
    ce = 1'b0;
    rd1(0, 5'd4, 0);
    ce = 1'b1;
    rd1(0, 5'd4, 1);
    $display("clock enable done");
  endtask : t_ce
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    t_dev;
    t_cfg;
    t_ref;
    t_ce;
    end_of_test;
  end
endmodule : hdg_gen_tb
